//--- inc/stm_regs.vh
// Register offsets, field positions, reset values and timing counts of the timer.
`ifndef STM_REGS_VH
`define STM_REGS_VH

// ----------------------------------------
// Byte offsets of the word registers
// ----------------------------------------
`define STM_OFS_RUN_CTRL   6'h00
`define STM_OFS_MODE_CTRL  6'h04
`define STM_OFS_COUNT_LO   6'h08
`define STM_OFS_COUNT_HI   6'h0c
`define STM_OFS_CMPA_LO    6'h10
`define STM_OFS_CMPA_HI    6'h14
`define STM_OFS_PERIOD     6'h18
`define STM_OFS_FLAGS      6'h1c
`define STM_OFS_PRESCALE   6'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STM_RUN_BIT        3
`define STM_MODE_HI        7
`define STM_MODE_LO        6
`define STM_PIN_FN_HI      5
`define STM_PIN_FN_LO      4
`define STM_OC_BIT         3
`define STM_POL_BIT        2
`define STM_DPX_BIT        1
`define STM_CCLR_BIT       0
`define STM_FLAG_A_BIT     0
`define STM_FLAG_P_BIT     1

// ----------------------------------------
// Mode and pin function codes
// ----------------------------------------
`define STM_MODE_CMP       2'h0
`define STM_MODE_CAP       2'h1
`define STM_MODE_PWM       2'h2
`define STM_MODE_TMR       2'h3
`define STM_FN_00          2'h0
`define STM_FN_01          2'h1
`define STM_FN_10          2'h2
`define STM_FN_11          2'h3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define STM_RST_BYTE       8'h00
`define STM_RST_COUNT      16'h0000
`define STM_COUNT_MAX      16'hffff
`define STM_LOW_BYTE_MAX   8'hff

`endif

//--- hdl/stm_timer.v
// Sixteen bit compare, capture and PWM timer with an Avalon-MM register slave.
`timescale 1ns/10ps

`include "stm_regs.vh"

module stm_timer (
  // Clock and reset.
  input  wire        ref_clk,
  input  wire        rst_b,
  // Avalon-MM slave.
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Timer pins.
  input  wire        capture_input_pin,
  output reg         timer_output_pin,
  // Interrupt requests.
  output reg         compare_a_flag,
  output reg         compare_p_flag
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg        run_bit;
  reg        run_q;
  reg  [7:0] mode_ctrl;
  reg  [15:0] compare_a_value;
  reg  [7:0] period_compare_reg;
  reg  [7:0] prescale;
  reg  [7:0] pre_cnt;
  reg  [15:0] count;
  reg        pin_state;
  reg        ack;
  reg  [2:0] cap_sync;
  reg        cap_level;

  // Control fields of the mode register, named for the logic below.
  wire [1:0] mode_sel             = mode_ctrl[`STM_MODE_HI:`STM_MODE_LO];
  wire [1:0] pin_fn               = mode_ctrl[`STM_PIN_FN_HI:`STM_PIN_FN_LO];
  wire       output_control_bit   = mode_ctrl[`STM_OC_BIT];
  wire       output_polarity_bit  = mode_ctrl[`STM_POL_BIT];
  wire       duty_period_select   = mode_ctrl[`STM_DPX_BIT];
  wire       counter_clear_select = mode_ctrl[`STM_CCLR_BIT];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // A request is taken only in the cycle before the acknowledge.
  wire       take     = (read | write) & ~ack;
  wire       wr_en    = take & write & byteenable[0];
  wire [5:0] word_adr = {address[5:2], 2'h0};

  // One write strobe per register except the read-only count.
  wire wr_run     = wr_en & (word_adr == `STM_OFS_RUN_CTRL);
  wire wr_mode    = wr_en & (word_adr == `STM_OFS_MODE_CTRL);
  wire wr_cmpa_lo = wr_en & (word_adr == `STM_OFS_CMPA_LO);
  wire wr_cmpa_hi = wr_en & (word_adr == `STM_OFS_CMPA_HI);
  wire wr_period  = wr_en & (word_adr == `STM_OFS_PERIOD);
  wire wr_flags   = wr_en & (word_adr == `STM_OFS_FLAGS);
  wire wr_pre     = wr_en & (word_adr == `STM_OFS_PRESCALE);

  // ----------------------------------------
  // Timer clock and comparators
  // ----------------------------------------

  // Run rising edge seen one cycle after the write lands.
  wire run_rise = run_bit & ~run_q;

  // The timer clock is an enable pulse every prescale+1 cycles. It is held off in the
  // restart cycle, whose count is still the stale one, so no false match fires there.
  wire tick = run_bit & ~run_rise & (pre_cnt == prescale);

  // Comparator P matches the count against {period-1, 8'hff}, so the register sets the top byte only; zero means full wrap.
  wire [7:0] period_m1 = period_compare_reg - 8'h01;
  wire       ovf_hit   = (count == `STM_COUNT_MAX);
  wire       a_hit     = (count == compare_a_value);
  wire       p_hit     = (period_compare_reg == `STM_RST_BYTE) ? ovf_hit :
                         (count == {period_m1, `STM_LOW_BYTE_MAX});

  // Single pulse shares the PWM mode code; a zero compare A raises no A event in compare or timer mode, though it can still clear the count.
  wire pulse_mode = (mode_sel == `STM_MODE_PWM) & (pin_fn == `STM_FN_11);
  wire a_zero     = (compare_a_value == `STM_RST_COUNT);

  // ----------------------------------------
  // Capture input
  // ----------------------------------------

  // The pin passes three flops; a level counts once the last two agree.
  wire cap_stable = (cap_sync[1] == cap_sync[2]);
  wire cap_rise   = cap_stable & cap_sync[2] & ~cap_level;
  wire cap_fall   = cap_stable & ~cap_sync[2] & cap_level;

  reg cap_edge;
  always @* begin
    case (pin_fn)
      `STM_FN_00: cap_edge = cap_rise;
      `STM_FN_01: cap_edge = cap_fall;
      `STM_FN_10: cap_edge = cap_rise | cap_fall;
      default:    cap_edge = 1'b0;
    endcase
  end

  wire cap_take = (mode_sel == `STM_MODE_CAP) & run_bit & cap_edge;

  // ----------------------------------------
  // Counter clear and event selection
  // ----------------------------------------

  // Matches count only on a timer tick, so one match gives one event.
  reg clr_hit;
  reg a_event;
  reg p_event;
  reg pulse_end;

  always @* begin
    clr_hit   = 1'b0;
    a_event   = 1'b0;
    p_event   = 1'b0;
    pulse_end = 1'b0;
    case (mode_sel)
      `STM_MODE_CMP,
      `STM_MODE_TMR: begin
        if (counter_clear_select) begin
          clr_hit = a_hit;
          p_event = 1'b0;
        end else begin
          clr_hit = p_hit;
          p_event = tick & p_hit;
        end
        a_event = tick & a_hit & ~a_zero;
      end
      `STM_MODE_PWM: begin
        if (pulse_mode) begin
          pulse_end = tick & a_hit;
          a_event   = pulse_end;
        end else begin
          clr_hit = duty_period_select ? a_hit : p_hit;
          a_event = tick & a_hit;
          p_event = tick & p_hit;
        end
      end
      `STM_MODE_CAP: begin
        clr_hit = p_hit;
        p_event = tick & p_hit;
        a_event = cap_take;
      end
      default: begin
        clr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // PWM waveform
  // ----------------------------------------

  // Duty compare: with the duty at or above the period it never ends.
  reg pwm_act;
  always @* begin
    if (duty_period_select) begin
      pwm_act = (period_compare_reg == `STM_RST_BYTE) |
                (count < {period_compare_reg, 8'h00});
    end else begin
      pwm_act = (count < compare_a_value);
    end
  end

  // Active-level request for the PWM and single pulse codes.
  reg want_act;
  always @* begin
    case (pin_fn)
      `STM_FN_00: want_act = 1'b0;
      `STM_FN_01: want_act = 1'b1;
      `STM_FN_10: want_act = pwm_act;
      default:    want_act = run_bit & ~pulse_end;
    endcase
  end

  // ----------------------------------------
  // Compare mode pin level
  // ----------------------------------------

  // Setting to the level already held leaves the pin as it is.
  reg next_pin_state;
  always @* begin
    next_pin_state = pin_state;
    if (run_rise) begin
      next_pin_state = output_control_bit;
    end else if (a_event && (mode_sel == `STM_MODE_CMP)) begin
      case (pin_fn)
        `STM_FN_01: next_pin_state = 1'b0;
        `STM_FN_10: next_pin_state = 1'b1;
        `STM_FN_11: next_pin_state = ~pin_state;
        default:    next_pin_state = pin_state;
      endcase
    end
  end

  // Final pin: timer and capture modes leave it low and unused.
  reg next_pin;
  always @* begin
    case (mode_sel)
      `STM_MODE_CMP: next_pin = next_pin_state ^ output_polarity_bit;
      `STM_MODE_PWM: next_pin = ~(want_act ^ output_control_bit) ^ output_polarity_bit;
      default:       next_pin = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------

  // Unmapped addresses read as zero and ignore writes.
  reg [7:0] rd_byte;
  always @* begin
    case (word_adr)
      `STM_OFS_RUN_CTRL:  rd_byte = {4'h0, run_bit, 3'h0};
      `STM_OFS_MODE_CTRL: rd_byte = mode_ctrl;
      `STM_OFS_COUNT_LO:  rd_byte = count[7:0];
      `STM_OFS_COUNT_HI:  rd_byte = count[15:8];
      `STM_OFS_CMPA_LO:   rd_byte = compare_a_value[7:0];
      `STM_OFS_CMPA_HI:   rd_byte = compare_a_value[15:8];
      `STM_OFS_PERIOD:    rd_byte = period_compare_reg;
      `STM_OFS_FLAGS:     rd_byte = {6'h00, compare_p_flag, compare_a_flag};
      `STM_OFS_PRESCALE:  rd_byte = prescale;
      default:            rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------

  // Waitrequest drops for exactly one cycle, the cycle after the take.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ack         <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      ack         <= take;
      waitrequest <= ~take;
      if (take && read) begin
        readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------

  // A compare A match in single pulse mode switches the run bit off.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      run_bit            <= 1'b0;
      run_q              <= 1'b0;
      mode_ctrl          <= `STM_RST_BYTE;
      period_compare_reg <= `STM_RST_BYTE;
      prescale           <= `STM_RST_BYTE;
    end else begin
      run_q <= run_bit;
      if (pulse_end) begin
        run_bit <= 1'b0;
      end else if (wr_run) begin
        run_bit <= writedata[`STM_RUN_BIT];
      end
      if (wr_mode) begin
        mode_ctrl <= writedata[7:0];
      end
      if (wr_period) begin
        period_compare_reg <= writedata[7:0];
      end
      if (wr_pre) begin
        prescale <= writedata[7:0];
      end
    end
  end

  // Capture overrides a software write to compare A in the same cycle.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      compare_a_value <= `STM_RST_COUNT;
    end else if (cap_take) begin
      compare_a_value <= count;
    end else begin
      if (wr_cmpa_lo) begin
        compare_a_value[7:0] <= writedata[7:0];
      end
      if (wr_cmpa_hi) begin
        compare_a_value[15:8] <= writedata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Counter and prescaler
  // ----------------------------------------

  // The run rising edge and a clearing match on a tick zero the count; stopping keeps it.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      count   <= `STM_RST_COUNT;
      pre_cnt <= `STM_RST_BYTE;
    end else if (run_rise) begin
      count   <= `STM_RST_COUNT;
      pre_cnt <= `STM_RST_BYTE;
    end else if (run_bit) begin
      if (tick) begin
        pre_cnt <= `STM_RST_BYTE;
        if (clr_hit) begin
          count <= `STM_RST_COUNT;
        end else begin
          count <= count + 16'h0001;
        end
      end else begin
        pre_cnt <= pre_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Flags and pin
  // ----------------------------------------

  // Write one to clear; an event in the same cycle wins over it.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      if (a_event) begin
        compare_a_flag <= 1'b1;
      end else if (wr_flags && writedata[`STM_FLAG_A_BIT]) begin
        compare_a_flag <= 1'b0;
      end
      if (p_event) begin
        compare_p_flag <= 1'b1;
      end else if (wr_flags && writedata[`STM_FLAG_P_BIT]) begin
        compare_p_flag <= 1'b0;
      end
    end
  end

  // Synchroniser, filtered capture level and registered output pin.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cap_sync         <= 3'h0;
      cap_level        <= 1'b0;
      pin_state        <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      cap_sync <= {cap_sync[1:0], capture_input_pin};
      if (cap_stable) begin
        cap_level <= cap_sync[2];
      end
      pin_state        <= next_pin_state;
      timer_output_pin <= next_pin;
    end
  end

endmodule // stm_timer

//--- tb/stm_timer_asserts.sv
// Concurrent checks on the timer's bus handshake, flags and output pin.
`timescale 1ns/10ps
`include "stm_regs.vh"
module stm_timer_asserts (
  // Clock and reset.
  input wire        ref_clk,
  input wire        rst_b,
  // Register bus.
  input wire [5:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Pins and flags.
  input wire        capture_input_pin,
  input wire        timer_output_pin,
  input wire        compare_a_flag,
  input wire        compare_p_flag
);
  // ----
  // Shadow of mode and run
  // ----
  reg [7:0]  mode_s;
  reg        run_s;
  reg [1:0]  age;
  wire       take = write && waitrequest && byteenable[0];
  wire       clr = take && address == `STM_OFS_FLAGS;
  wire       lvl = (mode_s[4] ? mode_s[3] : !mode_s[3]) ^ mode_s[2];
  wire [1:0] md = mode_s[7:6];

  // Age saturates at three, so a long run never looks like a fresh start.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_s <= 8'h00;
      run_s  <= 1'b0;
      age    <= 2'h0;
    end else begin
      if (take && address == `STM_OFS_MODE_CTRL) begin
        mode_s <= writedata[7:0];
      end
      if (take && address == `STM_OFS_RUN_CTRL) begin
        run_s <= writedata[`STM_RUN_BIT];
      end
      age <= !run_s ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_flag_a_hold: assert property (compare_a_flag && !(clr && writedata[0]) |=> compare_a_flag)
    else $error("flag a dropped without a clear");
  a_flag_p_hold: assert property (compare_p_flag && !(clr && writedata[1]) |=> compare_p_flag)
    else $error("flag p dropped without a clear");
  a_keep_pin: assert property (mode_s[7:4] == 4'h0 && age == 2'h3 |=> $stable(timer_output_pin))
    else $error("pin moved with no-change function");
  a_timer_pin: assert property (md == `STM_MODE_TMR && age == 2'h3 |-> !timer_output_pin)
    else $error("pin driven in timer mode");
  a_pwm_forced: assert property (md == `STM_MODE_PWM && !mode_s[5] && age == 2'h3 |-> timer_output_pin == lvl)
    else $error("forced pwm level wrong");
  a_run_initial: assert property (md == `STM_MODE_CMP && age == 2'h1 |-> timer_output_pin == (mode_s[3] ^ mode_s[2]))
    else $error("pin not at initial level after start");
  a_no_p_flag: assert property (md[0] == md[1] && mode_s[0] && age == 2'h3 |-> !$rose(compare_p_flag))
    else $error("flag p raised while clearing on a");

  c_run_start: cover property (age == 2'h1);
  c_flag_a: cover property ($rose(compare_a_flag));
  c_flag_p: cover property ($rose(compare_p_flag));
endmodule // stm_timer_asserts

bind stm_timer stm_timer_asserts stm_timer_asserts_i (.ref_clk, .rst_b, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .capture_input_pin, .timer_output_pin, .compare_a_flag, .compare_p_flag);

//--- tb/stm_pin_partner.sv
// Pin-side model: a capture source driven on command and a load that counts high cycles.
`timescale 1ns/10ps
module stm_pin_partner (
  // Clock.
  input wire        ref_clk,
  // Timer pins.
  input wire        timer_output_pin,
  output reg        capture_input_pin,
  // Bench commands and measurement.
  input wire        cap_level,
  input wire        count_en,
  output reg [15:0] high_cycles
);
  initial capture_input_pin = 1'b0;
  initial high_cycles = 16'h0000;

  // Edges leave just after a clock edge; the count restarts whenever the window closes.
  always @(posedge ref_clk) begin
    capture_input_pin <= cap_level;
    high_cycles <= !count_en ? 16'h0000 : high_cycles + {15'h0000, timer_output_pin};
  end
endmodule // stm_pin_partner

//--- tb/standard_timer_compare_pwm_test.sv
// Self-checking bench: register access, compare, timer, PWM and capture runs.
`timescale 1ns/10ps
`include "stm_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("mismatch %0t %h %h", $time, g, e); end end
module standard_timer_compare_pwm_test;
  // ----
  // Signals
  // ----
  reg         ref_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg [5:0]   address = 6'h00;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg [31:0]  writedata = 32'h0;
  reg [3:0]   byteenable = 4'h0;
  reg         cap_level = 1'b0;
  reg         count_en = 1'b0;
  wire [31:0] readdata;
  wire        waitrequest, capture_input_pin, timer_output_pin, compare_a_flag, compare_p_flag;
  wire [15:0] high_cycles;
  reg [7:0]   q;
  reg [1:0]   fn;
  reg         lvl;
  integer     miscompares = 0;
  integer     checked = 0;
  integer     i, n, m;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  stm_timer stm_timer_i (.ref_clk, .rst_b, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .capture_input_pin, .timer_output_pin, .compare_a_flag, .compare_p_flag);
  stm_pin_partner stm_pin_partner_i (.ref_clk, .timer_output_pin, .capture_input_pin, .cap_level, .count_en,
    .high_cycles);

  task summarize;
    begin
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  // One Avalon access; a slave that never answers ends the run rather than hanging it.
  task bus(input reg wr, input reg [5:0] a, input reg [7:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      address <= a;
      writedata <= {24'h000000, d};
      read <= !wr;
      write <= wr;
      byteenable <= 4'h1;
      k = 0;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0 && k < 20) begin
        @(posedge ref_clk);
        k = k + 1;
      end
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      if (k >= 20) begin
        miscompares++;
        summarize;
      end
    end
  endtask

  task ck(input reg [5:0] a, input reg [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      `CHK(q, e);
    end
  endtask

  // Mode changes only while stopped, since a running change gives an undefined waveform.
  task cfg(input reg [7:0] md, input reg [15:0] a, input reg [7:0] p);
    begin
      bus(1'b1, `STM_OFS_RUN_CTRL, 8'h00);
      bus(1'b1, `STM_OFS_MODE_CTRL, md);
      bus(1'b1, `STM_OFS_CMPA_LO, a[7:0]);
      bus(1'b1, `STM_OFS_CMPA_HI, a[15:8]);
      bus(1'b1, `STM_OFS_PERIOD, p);
      bus(1'b1, `STM_OFS_FLAGS, 8'h03);
      bus(1'b1, `STM_OFS_RUN_CTRL, 8'h08);
    end
  endtask

  task wt(input reg p, input integer lim);
    begin
      n = 0;
      @(negedge ref_clk);
      while ((p ? compare_p_flag : compare_a_flag) !== 1'b1 && n < lim) begin
        @(negedge ref_clk);
        n = n + 1;
      end
    end
  endtask

  task pwm(input reg [7:0] md, input reg [15:0] a, input integer len, input integer lo, input integer hi);
    begin
      cfg(md, a, 8'h01);
      repeat (4) @(posedge ref_clk);
      count_en <= 1'b1;
      repeat (len) @(posedge ref_clk);
      count_en <= 1'b0;
      @(negedge ref_clk);
      `CHK(high_cycles >= lo && high_cycles <= hi, 1'b1);
    end
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, a writable byte, the read-only count and an unmapped place.
    ck(`STM_OFS_MODE_CTRL, 8'h00);
    ck(`STM_OFS_PERIOD, 8'h00);
    ck(6'h3c, 8'h00);
    bus(1'b1, `STM_OFS_PERIOD, 8'ha5);
    ck(`STM_OFS_PERIOD, 8'ha5);
    bus(1'b1, `STM_OFS_COUNT_LO, 8'hff);
    ck(`STM_OFS_COUNT_LO, 8'h00);
    // Every pin function against both initial levels and both polarities.
    for (i = 0; i < 16; i++) begin
      fn = i[1:0];
      cfg({`STM_MODE_CMP, fn, i[2], i[3], 2'b01}, 16'h0005, 8'h00);
      @(negedge ref_clk);
      `CHK(timer_output_pin, i[2] ^ i[3]);
      wt(1'b0, 40);
      `CHK(n < 40, 1'b1);
      @(negedge ref_clk);
      lvl = fn == 2'h0 ? i[2] : fn == 2'h1 ? 1'b0 : fn == 2'h2 ? 1'b1 : !i[2];
      `CHK(timer_output_pin, lvl ^ i[3]);
    end
    // Compare and timer modes share the clearing and flag behaviour.
    for (m = 0; m < 2; m++) begin
      fn = m ? `STM_MODE_TMR : `STM_MODE_CMP;
      cfg({fn, 6'h01}, 16'h0300, 8'h01);
      wt(1'b0, 800);
      `CHK(n >= 760 && n <= 775, 1'b1);
      `CHK(compare_p_flag, 1'b0);
      cfg({fn, 6'h00}, 16'h0010, 8'h02);
      wt(1'b1, 600);
      `CHK(n >= 500 && n <= 515, 1'b1);
      `CHK(compare_a_flag, 1'b1);
      ck(`STM_OFS_COUNT_HI, 8'h00);
    end
    // PWM duty, full duty, polarity, swapped roles and forced levels.
    pwm(8'ha8, 16'h0010, 256, 15, 17);
    `CHK(compare_a_flag & compare_p_flag, 1'b1);
    pwm(8'ha8, 16'h0100, 256, 256, 256);
    pwm(8'hac, 16'h0010, 256, 239, 241);
    pwm(8'haa, 16'h01ff, 512, 255, 257);
    pwm(8'h88, 16'h0010, 256, 0, 0);
    pwm(8'h98, 16'h0010, 256, 256, 256);
    pwm(8'hb8, 16'h0010, 256, 12, 14);
    // Capture on each edge selection.
    for (i = 0; i < 4; i++) begin
      fn = i[1:0];
      cfg({`STM_MODE_CAP, fn, 4'h0}, 16'h0000, 8'h00);
      cap_level <= 1'b1;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(compare_a_flag, i == 0 || i == 2);
      bus(1'b1, `STM_OFS_FLAGS, 8'h03);
      cap_level <= 1'b0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(compare_a_flag, i == 1 || i == 2);
    end
    // Stop holds the count, restart zeroes it, then a full overflow with period zero.
    cfg(8'hc0, 16'h0000, 8'h00);
    repeat (700) @(posedge ref_clk);
    bus(1'b1, `STM_OFS_RUN_CTRL, 8'h00);
    ck(`STM_OFS_COUNT_HI, 8'h02);
    repeat (20) @(posedge ref_clk);
    ck(`STM_OFS_COUNT_HI, 8'h02);
    bus(1'b1, `STM_OFS_RUN_CTRL, 8'h08);
    ck(`STM_OFS_COUNT_HI, 8'h00);
    wt(1'b1, 66000);
    `CHK(n >= 65520 && n <= 65540, 1'b1);
    `CHK(compare_a_flag, 1'b0);
    summarize;
  end
endmodule // standard_timer_compare_pwm_test
